//--- src/tdm_pkg.sv
/*
  Shared constants and types for the TDM codec serial port with DMA.
  Assumes a single system clock and an AHB-Lite master with 32-bit data.
*/
`default_nettype none

package tdm_pkg;
  localparam int WORD_BITS = 16;
  localparam int SLOTS_ACTIVE = 5;
  localparam int CHANS = 8;
  localparam int RX_CHAN = 2;
  localparam int TX_CHAN = 6;
  localparam int BUF_WORDS = 8;
  localparam int SCLK_HZ = 12288000;
  localparam int FRAME_HZ = 48000;
  localparam int FRAME_BITS = SCLK_HZ / FRAME_HZ;

  // Byte offsets inside the block's 4 KB window.
  localparam logic [11:0] A_RX_CTRL = 12'h000;
  localparam logic [11:0] A_TX_CTRL = 12'h004;
  localparam logic [11:0] A_RX_DIV = 12'h008;
  localparam logic [11:0] A_RX_CMP = 12'h00c;
  localparam logic [11:0] A_TX_CMP = 12'h010;
  localparam logic [11:0] A_RX_SEL = 12'h014;
  localparam logic [11:0] A_TX_SEL = 12'h018;
  localparam logic [11:0] A_STATUS = 12'h01c;
  localparam logic [3:0] PAGE_DMA = 4'h1;
  localparam logic [3:0] PAGE_RXMEM = 4'h2;
  localparam logic [3:0] PAGE_TXMEM = 4'h3;

  // Register index inside one DMA channel's 32-byte group.
  localparam logic [2:0] R_INDEX = 3'h0;
  localparam logic [2:0] R_MODIFY = 3'h1;
  localparam logic [2:0] R_COUNT = 3'h2;
  localparam logic [2:0] R_CHAIN = 3'h3;
  localparam logic [2:0] R_GENERAL = 3'h4;

  // Control register fields.
  localparam int CTL_EN = 0;
  localparam int CTL_CHAIN = 1;

  localparam logic [31:0] RST_CTRL = 32'h00000000;
  localparam logic [31:0] RST_DIV = 32'h00ff0000;
  localparam logic [31:0] RST_CMP = 32'h00000000;
  localparam logic [31:0] RST_SEL = 32'h0000001f;
  localparam logic [15:0] RST_MOD = 16'h0001;
  localparam logic [15:0] RST_CNT = 16'h0005;
  localparam logic [2:0] AHB_WORD = 3'h2;

  typedef struct packed {
    logic [15:0] idx;
    logic [15:0] mod;
    logic [15:0] cnt;
    logic [15:0] cp;
    logic [31:0] gp;
  } tdm_dma_s;

  typedef struct packed {
    logic [11:0] addr;
    logic wr;
  } tdm_bus_s;
endpackage

`default_nettype wire

//--- src/tdm_port.sv
/*
  TDM serial port toward an audio codec, with register file on AHB-Lite,
  eight DMA channel register sets and small local sample buffers.
  Assumes the codec bit clock and data are synchronous to i_clk_sys.
*/
`default_nettype none

// Overview of operation
// - Sixteen-bit words in both directions.
// - Bit clock always comes from codec.
// - Sync one bit before first word MSB.
// - Active-high one-bit sync pulse per frame.
// - Frame sync generated internally at 48 kHz.
// - Frame period is 256 bit clocks.
// - Divisor upper half holds ratio minus one.
// - No companding; slot words pass unchanged.
// - Five active words per frame.
// - Slots 0-4 enabled, others ignored.
// - Buffers hold eight words each.
// - DMA with chaining for both directions.
// - Channel reloads itself on interrupt request.
// - Eight channels with five registers each.
// - Only A-side channels move data.
// - Request raised when count reaches zero.
// - Codec drives clock, input; port drives sync, output.
module tdm_port
  import tdm_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Codec link.
  input wire logic i_bit_clk,
  input wire logic i_sdata_in,
  output logic o_sync,
  output logic o_sdata_out,
  // DMA completion requests.
  output logic o_rx_dma_irq,
  output logic o_tx_dma_irq
);
  import tdm_pkg::*;

  tdm_bus_s dp;
  logic [31:0] rx_ctl;
  logic [31:0] tx_ctl;
  logic [31:0] rx_div;
  logic [31:0] rx_cmp;
  logic [31:0] tx_cmp;
  logic [31:0] rx_sel;
  logic [31:0] tx_sel;
  logic [1:0] sts;
  tdm_dma_s ch [CHANS];
  logic [15:0] rl_idx [CHANS];
  logic [15:0] rl_cnt [CHANS];
  logic [15:0] rx_mem [BUF_WORDS];
  logic [15:0] tx_mem [BUF_WORDS];
  logic [31:0] rd_val;
  logic bclk_q;
  logic [15:0] pos;
  logic [15:0] next_pos;
  logic [15:0] tsh;
  logic [15:0] rsh;
  logic [15:0] fq [2];
  logic fwp;
  logic frp;
  logic [1:0] fcnt;
  logic [15:0] tx_word;

  function automatic logic slot_on(input logic [31:0] sel, input logic [15:0] p);
    slot_on = (p[15:9] == 7'h0) && sel[p[8:4]];
  endfunction

  function automatic tdm_dma_s dma_step(input tdm_dma_s c, input logic [15:0] ri,
                                        input logic [15:0] rc, input logic chain);
    dma_step = c;
    dma_step.idx = c.idx + c.mod;
    dma_step.cnt = c.cnt - 16'h1;
    if (c.cnt == 16'h1 && chain) begin
      dma_step.idx = ri;
      dma_step.cnt = rc;
    end
  endfunction

  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire wr_dma = dp.wr & (dp.addr[11:8] == PAGE_DMA);
  wire [2:0] wc = dp.addr[7:5];
  wire bedge = i_bit_clk & ~bclk_q;
  wire run = rx_ctl[CTL_EN];

  // Bus slave: reads answer with no wait, writes take one wait state.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dp <= '0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h00000000;
    end else begin
      dp.wr <= addr_ok & i_hwrite & (i_hsize == AHB_WORD);
      dp.addr <= i_haddr[11:0];
      o_hreadyout <= ~(addr_ok & i_hwrite);
      o_hresp <= 1'b0;
      if (addr_ok && !i_hwrite) begin
        o_hrdata <= rd_val;
      end
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    case (i_haddr[11:8])
      PAGE_DMA: begin
        case (i_haddr[4:2])
          R_INDEX: rd_val = {16'h0000, ch[i_haddr[7:5]].idx};
          R_MODIFY: rd_val = {16'h0000, ch[i_haddr[7:5]].mod};
          R_COUNT: rd_val = {16'h0000, ch[i_haddr[7:5]].cnt};
          R_CHAIN: rd_val = {16'h0000, ch[i_haddr[7:5]].cp};
          R_GENERAL: rd_val = ch[i_haddr[7:5]].gp;
          default: rd_val = 32'h00000000;
        endcase
      end
      PAGE_RXMEM: rd_val = {16'h0000, rx_mem[i_haddr[4:2]]};
      PAGE_TXMEM: rd_val = {16'h0000, tx_mem[i_haddr[4:2]]};
      default: begin
        case (i_haddr[11:0])
          A_RX_CTRL: rd_val = rx_ctl;
          A_TX_CTRL: rd_val = tx_ctl;
          A_RX_DIV: rd_val = rx_div;
          A_RX_CMP: rd_val = rx_cmp;
          A_TX_CMP: rd_val = tx_cmp;
          A_RX_SEL: rd_val = rx_sel;
          A_TX_SEL: rd_val = tx_sel;
          A_STATUS: rd_val = {pos, 12'h000, fcnt, sts};
          default: rd_val = 32'h00000000;
        endcase
      end
    endcase
  end

  // Port configuration registers.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_ctl <= RST_CTRL;
      tx_ctl <= RST_CTRL;
      rx_div <= RST_DIV;
      rx_cmp <= RST_CMP;
      tx_cmp <= RST_CMP;
      rx_sel <= RST_SEL;
      tx_sel <= RST_SEL;
    end else if (dp.wr) begin
      case (dp.addr)
        A_RX_CTRL: rx_ctl <= i_hwdata;
        A_TX_CTRL: tx_ctl <= i_hwdata;
        A_RX_DIV: rx_div <= i_hwdata;
        A_RX_CMP: rx_cmp <= i_hwdata;
        A_TX_CMP: tx_cmp <= i_hwdata;
        A_RX_SEL: rx_sel <= i_hwdata;
        A_TX_SEL: tx_sel <= i_hwdata;
        default: rx_ctl <= rx_ctl;
      endcase
    end
  end

  assign next_pos = (pos == rx_div[31:16]) ? 16'h0000 : pos + 16'h1;

  wire tx_take = bedge & run & tx_ctl[CTL_EN] & (next_pos[3:0] == 4'h0) & slot_on(tx_sel, next_pos);
  wire tx_live = tx_ctl[CTL_EN] & (ch[TX_CHAN].cnt != 16'h0);
  wire push = bedge & run & (pos[3:0] == 4'hf) & slot_on(rx_sel, pos);
  wire in_ready = (fcnt != 2'h2);
  wire pop = (fcnt != 2'h0) & rx_ctl[CTL_EN] & (ch[RX_CHAN].cnt != 16'h0);

  assign tx_word = tx_live ? tx_mem[ch[TX_CHAN].idx[2:0]] : 16'h0000;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= i_bit_clk;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos <= 16'h0000;
      o_sync <= 1'b0;
    end else if (!run) begin
      pos <= rx_div[31:16] - 16'h1;
      o_sync <= 1'b0;
    end else if (bedge) begin
      pos <= next_pos;
      o_sync <= (next_pos == rx_div[31:16]);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tsh <= 16'h0000;
      o_sdata_out <= 1'b0;
    end else if (bedge) begin
      if (next_pos[3:0] == 4'h0) begin
        o_sdata_out <= tx_take & tx_word[WORD_BITS-1];
        tsh <= tx_take ? {tx_word[14:0], 1'b0} : 16'h0000;
      end else begin
        o_sdata_out <= tsh[15];
        tsh <= {tsh[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsh <= 16'h0000;
    end else if (bedge) begin
      rsh <= {rsh[14:0], i_sdata_in};
    end
  end

  // Two-entry buffer between the receiver and the DMA channel.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fwp <= 1'b0;
      frp <= 1'b0;
      fcnt <= 2'h0;
      fq[0] <= 16'h0000;
      fq[1] <= 16'h0000;
    end else begin
      if (push && in_ready) begin
        fq[fwp] <= {rsh[14:0], i_sdata_in};
        fwp <= ~fwp;
      end
      if (pop) begin
        frp <= ~frp;
      end
      fcnt <= fcnt + {1'b0, push & in_ready} - {1'b0, pop};
    end
  end

  // Sticky overflow and underrun flags; a new event beats the clear.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sts <= 2'h0;
    end else begin
      sts <= (sts & ~((dp.wr && dp.addr == A_STATUS) ? i_hwdata[1:0] : 2'h0))
             | {tx_take & ~tx_live, push & ~in_ready};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < CHANS; i++) begin
        ch[i] <= '0;
        ch[i].mod <= RST_MOD;
        rl_idx[i] <= 16'h0000;
        rl_cnt[i] <= RST_CNT;
      end
    end else begin
      if (pop) begin
        ch[RX_CHAN] <= dma_step(ch[RX_CHAN], rl_idx[RX_CHAN], rl_cnt[RX_CHAN], rx_ctl[CTL_CHAIN]);
      end
      if (tx_take && tx_live) begin
        ch[TX_CHAN] <= dma_step(ch[TX_CHAN], rl_idx[TX_CHAN], rl_cnt[TX_CHAN], tx_ctl[CTL_CHAIN]);
      end
      if (wr_dma) begin
        case (dp.addr[4:2])
          R_INDEX: ch[wc].idx <= i_hwdata[15:0];
          R_MODIFY: ch[wc].mod <= i_hwdata[15:0];
          R_COUNT: ch[wc].cnt <= i_hwdata[15:0];
          R_CHAIN: begin
            ch[wc].cp <= i_hwdata[15:0];
            rl_idx[wc] <= ch[wc].idx;
            rl_cnt[wc] <= ch[wc].cnt;
          end
          R_GENERAL: ch[wc].gp <= i_hwdata;
          default: ch[wc].gp <= ch[wc].gp;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_dma_irq <= 1'b0;
      o_tx_dma_irq <= 1'b0;
    end else begin
      o_rx_dma_irq <= pop & (ch[RX_CHAN].cnt == 16'h1);
      o_tx_dma_irq <= tx_take & tx_live & (ch[TX_CHAN].cnt == 16'h1);
    end
  end

  // Sample buffers carry no reset; software loads the transmit buffer before use.
  always_ff @(posedge i_clk_sys) begin
    if (pop) begin
      rx_mem[ch[RX_CHAN].idx[2:0]] <= fq[frp];
    end
    if (dp.wr && dp.addr[11:8] == PAGE_TXMEM) begin
      tx_mem[dp.addr[4:2]] <= i_hwdata[15:0];
    end
  end
endmodule

`default_nettype wire

//--- test/tdm_codec_model.sv
/*
  Codec stand-in: makes the bit clock, sends slot words, collects sent words.
  Assumes it shares the system clock with the port under test.
*/
`default_nettype none

module tdm_codec_model (
  // Clock.
  input wire logic i_clk_sys,
  // Port side.
  input wire logic i_sync,
  input wire logic i_sdo,
  // Codec side.
  output logic o_bclk,
  output logic o_sdi,
  output logic [4:0][15:0] o_got,
  output int o_stray
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos;
  int np;
  logic [15:0] w;

  initial begin
    o_bclk = 1'b0;
    o_sdi = 1'b0;
    o_stray = 0;
    pos = 999;
  end

  always @(posedge i_clk_sys) begin
    o_bclk <= ~o_bclk;
    if (o_bclk) begin
      if (pos < 80) o_got[pos / 16][15 - pos % 16] <= i_sdo;
      else if (pos < 255 && i_sdo === 1'b1) o_stray <= o_stray + 1;
      np = (i_sync === 1'b1) ? 0 : pos + 1;
      pos = np;
      w = 16'h9c31 + 16'(np / 16) * 16'h0421;
      o_sdi <= (np < 80) ? w[15 - np % 16] : np[0];
    end
  end
endmodule

`default_nettype wire

//--- test/tdm_port_chk.sv
/*
  Checker for the TDM port: bus wait states, sync timing and request pulses.
  Assumes the codec bit clock is sampled synchronously by i_clk_sys.
*/
`default_nettype none

module tdm_port_chk (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Bus.
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  // Link and requests.
  input wire logic i_bit_clk,
  input wire logic o_sync,
  input wire logic o_sdata_out,
  input wire logic o_rx_dma_irq,
  input wire logic o_tx_dma_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic bclk_q;
  logic seen;
  logic [8:0] gap;
  wire logic bit_edge = i_bit_clk & ~bclk_q;
  wire logic taken = i_hsel & i_htrans[1] & i_hready;

  // Counts bit edges since the last edge that showed the sync bit.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bclk_q <= 1'b0;
      seen <= 1'b0;
      gap <= 9'h000;
    end else begin
      bclk_q <= i_bit_clk;
      if (bit_edge) begin
        seen <= seen | o_sync;
        gap <= o_sync ? 9'h001 : gap + 9'h001;
      end
    end
  end

  sequence wr_wait_s;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  wr_wait_a: assert property (taken && i_hwrite |=> wr_wait_s)
    else $error("write wait state wrong");
  rd_nowait_a: assert property (taken && !i_hwrite |=> o_hreadyout)
    else $error("read was stalled");
  sync_width_a: assert property (bit_edge && o_sync |=> !o_sync)
    else $error("sync longer than one bit");
  sync_hold_a: assert property (!bit_edge |=> $stable(o_sync))
    else $error("sync moved between bit edges");
  data_hold_a: assert property (!bit_edge |=> $stable(o_sdata_out))
    else $error("data moved between bit edges");
  frame_period_a: assert property (bit_edge && seen |-> o_sync == (gap == 9'h100))
    else $error("frame period not 256 bits");
  rx_irq_a: assert property ($rose(o_rx_dma_irq) |=> !o_rx_dma_irq [*8])
    else $error("receive request not a pulse");
  tx_irq_a: assert property ($rose(o_tx_dma_irq) |=> !o_tx_dma_irq [*8])
    else $error("transmit request not a pulse");
endmodule

`default_nettype wire

//--- test/test_tdm_codec_serial_port_dma.sv
/*
  Bench for the TDM port: registers over AHB-Lite and codec frame traffic.
  Assumes tdm_pkg, the checker and the codec stand-in are compiled first.
*/
`default_nettype none

module test_tdm_codec_serial_port_dma import tdm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp, bit_clk, sdata_in, sync, sdata_out, rx_irq, tx_irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [4:0][15:0] got;
  logic [11:0] ra[8];
  logic [31:0] rv[8];
  int stray, i;
  logic [31:0] st;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int rx_irqs = 0;
  int tx_irqs = 0;

  tdm_port dut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout), .i_hwdata(hwdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_bit_clk(bit_clk), .i_sdata_in(sdata_in), .o_sync(sync),
    .o_sdata_out(sdata_out), .o_rx_dma_irq(rx_irq), .o_tx_dma_irq(tx_irq));
  tdm_codec_model codec (.i_clk_sys(clk_sys), .i_sync(sync), .i_sdo(sdata_out), .o_bclk(bit_clk),
    .o_sdi(sdata_in), .o_got(got), .o_stray(stray));

  function automatic logic [11:0] dma(input int ch, input logic [2:0] r);
    return 12'h100 + 12'(ch * 32) + 12'(r) * 12'h004;
  endfunction
  function automatic logic [15:0] tx_w(input int n);
    return 16'h8001 ^ 16'(n * 16'h1357);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Address phase held until hready, then data phase held until hready.
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && n++ < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && n++ < 40);
    r = hrdata;
    if (n >= 40) mismatches++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h00000000, r);
    chk(what, exp, r);
    chk("bus response", 32'h00000000, {31'h0, hresp});
  endtask

  task automatic wait_sync;
    int n;
    n = 0;
    do @(posedge clk_sys); while (sync !== 1'b1 && n++ < 600);
    if (sync !== 1'b1) mismatches++;
    repeat (300) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (rx_irq === 1'b1) rx_irqs++;
    if (tx_irq === 1'b1) tx_irqs++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = AHB_WORD;
    hwdata = 32'h00000000;
    ra = '{A_RX_CTRL, A_TX_CTRL, A_RX_DIV, A_RX_CMP, A_TX_CMP, A_RX_SEL, A_TX_SEL, 12'h0f0};
    rv = '{RST_CTRL, RST_CTRL, RST_DIV, RST_CMP, RST_CMP, RST_SEL, RST_SEL, 32'h00000000};
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 8; i++) rd("reset value", ra[i], rv[i]);
    $display("reset value test done");
    for (i = 0; i < 8; i++) begin
      rd("modify reset", dma(i, R_MODIFY), {16'h0000, RST_MOD});
      wr(dma(i, R_GENERAL), 32'h5a000000 | i);
      rd("general reg", dma(i, R_GENERAL), 32'h5a000000 | i);
    end
    $display("channel register test done");
    for (i = 0; i < 5; i++) wr(12'h300 + 12'(4 * i), {16'h0000, tx_w(i)});
    for (i = RX_CHAN; i <= TX_CHAN; i += 4) begin
      wr(dma(i, R_INDEX), 32'h00000000);
      wr(dma(i, R_COUNT), 32'h00000005);
      wr(dma(i, R_CHAIN), 32'h00000001);
    end
    wr(A_TX_CTRL, 32'h00000003);
    wr(A_RX_CTRL, 32'h00000003);
    wait_sync();
    wait_sync();
    for (i = 0; i < 5; i++) begin
      chk("sent word", {16'h0000, tx_w(i)}, {16'h0000, got[i]});
      rd("received word", 12'h200 + 12'(4 * i), {16'h0000, 16'h9c31 + 16'(i) * 16'h0421});
    end
    chk("bits outside slots", 32'h00000000, 32'(stray));
    rd("rx count reload", dma(RX_CHAN, R_COUNT), 32'h00000005);
    chk("rx requests", 32'h00000002, 32'(rx_irqs));
    wr(A_TX_CTRL, 32'h00000001);
    wait_sync();
    rd("tx count stopped", dma(TX_CHAN, R_COUNT), 32'h00000000);
    rd("tx index advanced", dma(TX_CHAN, R_INDEX), 32'h00000005);
    chk("tx requests", 32'h00000003, 32'(tx_irqs));
    $display("stream test done");
    // With the transmit channel stopped, the next frame's slots must raise the sticky underrun flag.
    wait_sync();
    ahb(1'b0, A_STATUS, 32'h00000000, st);
    chk("underrun flag", 32'h00000002, {30'h0, st[1:0]});
    wr(A_STATUS, 32'h00000002);
    ahb(1'b0, A_STATUS, 32'h00000000, st);
    chk("flag cleared", 32'h00000000, {30'h0, st[1:0]});
    $display("status flag test done");
    tally_and_finish();
  end
endmodule

bind tdm_port tdm_port_chk chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .i_bit_clk(i_bit_clk),
  .o_sync(o_sync), .o_sdata_out(o_sdata_out), .o_rx_dma_irq(o_rx_dma_irq), .o_tx_dma_irq(o_tx_dma_irq));

`default_nettype wire
